// File: logic/bit_clock_pkg.sv
/*
  constants and types for the bit-clock selection block.
  assumes a 25 MHz sys_clk standing in for the crystal clock input.
*/
package bit_clock_pkg;
  localparam int unsigned sys_clk_hz = 25000000;
  localparam int unsigned crystal_hz = 3686400;
  // phase accumulator: step = rate_x10 * 16 * 2^acc_bits / (10 * sys_clk_hz)
  localparam int acc_bits = 32;
  localparam logic [3:0] code_timer = 4'hD;
  localparam logic [3:0] code_ext16 = 4'hE;
  localparam logic [3:0] code_ext1 = 4'hF;
  localparam logic [3:0] code_last_gen = 4'hC;
  localparam logic [2:0] addr_csa = 3'h0;
  localparam logic [2:0] addr_csb = 3'h1;
  localparam logic [2:0] addr_aux = 3'h2;
  localparam logic [2:0] addr_cmda = 3'h3;
  localparam logic [2:0] addr_cmdb = 3'h4;
  localparam logic [2:0] addr_stat = 3'h5;
  localparam int aux_table_bit = 7;
  localparam logic [7:0] cmd_rx_ext_set = 8'h08;
  localparam logic [7:0] cmd_rx_ext_clr = 8'h09;
  localparam logic [7:0] cmd_tx_ext_set = 8'h0A;
  localparam logic [7:0] cmd_tx_ext_clr = 8'h0B;
  localparam logic [3:0] mid_count = 4'h7;
  localparam logic [3:0] bit_count = 4'hF;
  localparam logic [3:0] frame_bits = 4'hB;
  typedef struct packed {
    logic [3:0] code;
    logic table_sel;
    logic extend;
  } clk_sel_t;
  typedef struct packed {
    logic tick;
    logic is_1x;
  } clk_en_t;
endpackage

// File: logic/rate_select.sv
/*
  one direction's source selector: rate table, phase accumulator, source mux.
  assumes timer and external ticks are single-cycle pulses on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rate_select (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // selection
  input wire bit_clock_pkg::clk_sel_t sel,
  input wire logic [31:0] xtal_scale,
  // tick sources
  input wire logic timer_tick,
  input wire logic ext_tick,
  // result
  output var bit_clock_pkg::clk_en_t en
);
  logic [31:0] rate_x10;
  logic [bit_clock_pkg::acc_bits-1:0] acc_reg, acc_next;
  logic [bit_clock_pkg::acc_bits:0] sum;
  logic [63:0] step_wide;
  bit_clock_pkg::clk_en_t en_reg, en_next;
  // ==========
  // rate tables, bit rates times ten
  always_comb begin
    rate_x10 = 32'h0;
    case ({sel.table_sel, sel.extend})
      2'b00: case (sel.code)
        4'h0: rate_x10 = 32'd500; 4'h1: rate_x10 = 32'd1100; 4'h2: rate_x10 = 32'd1345;
        4'h3: rate_x10 = 32'd2000; 4'h4: rate_x10 = 32'd3000; 4'h5: rate_x10 = 32'd6000;
        4'h6: rate_x10 = 32'd12000; 4'h7: rate_x10 = 32'd10500; 4'h8: rate_x10 = 32'd24000;
        4'h9: rate_x10 = 32'd48000; 4'hA: rate_x10 = 32'd72000; 4'hB: rate_x10 = 32'd96000;
        4'hC: rate_x10 = 32'd384000; default: rate_x10 = 32'h0;
      endcase
      2'b01: case (sel.code)
        4'h0: rate_x10 = 32'd750; 4'h1: rate_x10 = 32'd1100; 4'h2: rate_x10 = 32'd1345;
        4'h3: rate_x10 = 32'd1500; 4'h4: rate_x10 = 32'd36000; 4'h5: rate_x10 = 32'd144000;
        4'h6: rate_x10 = 32'd288000; 4'h7: rate_x10 = 32'd576000; 4'h8: rate_x10 = 32'd1152000;
        4'h9: rate_x10 = 32'd48000; 4'hA: rate_x10 = 32'd18000; 4'hB: rate_x10 = 32'd96000;
        4'hC: rate_x10 = 32'd192000; default: rate_x10 = 32'h0;
      endcase
      2'b10: case (sel.code)
        4'h0: rate_x10 = 32'd750; 4'h1: rate_x10 = 32'd1100; 4'h2: rate_x10 = 32'd1345;
        4'h3: rate_x10 = 32'd1500; 4'h4: rate_x10 = 32'd3000; 4'h5: rate_x10 = 32'd6000;
        4'h6: rate_x10 = 32'd12000; 4'h7: rate_x10 = 32'd20000; 4'h8: rate_x10 = 32'd24000;
        4'h9: rate_x10 = 32'd48000; 4'hA: rate_x10 = 32'd18000; 4'hB: rate_x10 = 32'd96000;
        4'hC: rate_x10 = 32'd192000; default: rate_x10 = 32'h0;
      endcase
      default: case (sel.code)
        4'h0: rate_x10 = 32'd500; 4'h1: rate_x10 = 32'd1100; 4'h2: rate_x10 = 32'd1345;
        4'h3: rate_x10 = 32'd2000; 4'h4: rate_x10 = 32'd36000; 4'h5: rate_x10 = 32'd144000;
        4'h6: rate_x10 = 32'd288000; 4'h7: rate_x10 = 32'd576000; 4'h8: rate_x10 = 32'd1152000;
        4'h9: rate_x10 = 32'd48000; 4'hA: rate_x10 = 32'd72000; 4'hB: rate_x10 = 32'd96000;
        4'hC: rate_x10 = 32'd384000; default: rate_x10 = 32'h0;
      endcase
    endcase
  end
  // ==========
  // 16X tick generation and source mux
  // xtal_scale is the per-unit step for one (rate_x10) at the set input clock
  assign step_wide = 64'(rate_x10) * 64'(xtal_scale);
  assign sum = {1'b0, acc_reg} + {1'b0, step_wide[47:16]};
  always_comb begin
    acc_next = acc_reg;
    en_next.tick = 1'b0;
    en_next.is_1x = 1'b0;
    if (sel.code <= bit_clock_pkg::code_last_gen) begin
      acc_next = sum[bit_clock_pkg::acc_bits-1:0];
      en_next.tick = sum[bit_clock_pkg::acc_bits];
    end else if (sel.code == bit_clock_pkg::code_timer) begin
      en_next.tick = timer_tick;
    end else if (sel.code == bit_clock_pkg::code_ext16) begin
      en_next.tick = ext_tick;
    end else begin
      en_next.tick = ext_tick;
      en_next.is_1x = 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_reg <= '0;
      en_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      en_reg <= en_next;
    end
  end
  assign en = en_reg;
endmodule
`default_nettype wire

// File: logic/uart_bit_clock_select.sv
/*
  two-channel bit-clock selection with receiver start-bit sampling schedule.
  assumes registers are written over a one-cycle strobe port on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_bit_clock_select (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // clock sources
  input wire logic timer_out,
  input wire logic input_pin_three,
  input wire logic input_pin_four,
  input wire logic ext_tx_b,
  input wire logic ext_rx_b,
  // serial inputs
  input wire logic rx_line_a,
  input wire logic rx_line_b,
  // enables out
  output logic tx_clk_en_a,
  output logic tx_clk_en_b,
  output logic rx_sample_a,
  output logic rx_sample_b,
  output logic [1:0] rx_busy
);
  // step per rate_x10: 16 * 2^32 / (10 * 25e6), scaled by 2^16 in rate_select
  localparam logic [31:0] xtal_scale = 32'h0112_E0BE;
  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_mid = 2'b01,
    rx_bits = 2'b10
  } rx_state_t;
  // ==========
  // registers
  logic [7:0] csa_reg, csa_next, csb_reg, csb_next;
  logic table_reg, table_next;
  logic [3:0] ext_reg, ext_next; // {rx_b, tx_b, rx_a, tx_a}
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] rx_busy_reg;
  always_comb begin
    csa_next = csa_reg;
    csb_next = csb_reg;
    table_next = table_reg;
    ext_next = ext_reg;
    rdata_next = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        bit_clock_pkg::addr_csa: csa_next = reg_wdata;
        bit_clock_pkg::addr_csb: csb_next = reg_wdata;
        bit_clock_pkg::addr_aux: table_next = reg_wdata[bit_clock_pkg::aux_table_bit];
        bit_clock_pkg::addr_cmda, bit_clock_pkg::addr_cmdb: begin
          case (reg_wdata)
            bit_clock_pkg::cmd_rx_ext_set: ext_next[{reg_addr[2], 1'b1}] = 1'b1;
            bit_clock_pkg::cmd_rx_ext_clr: ext_next[{reg_addr[2], 1'b1}] = 1'b0;
            bit_clock_pkg::cmd_tx_ext_set: ext_next[{reg_addr[2], 1'b0}] = 1'b1;
            bit_clock_pkg::cmd_tx_ext_clr: ext_next[{reg_addr[2], 1'b0}] = 1'b0;
            default: ext_next = ext_reg;
          endcase
        end
        default: ext_next = ext_reg;
      endcase
    end
    if (reg_rd && reg_addr == bit_clock_pkg::addr_stat) begin
      rdata_next = {table_reg, rx_busy_reg, 1'b0, ext_reg};
    end
  end
  // ==========
  // synchronisers and edge detect
  logic [4:0] s1_reg, s2_reg, s3_reg;
  logic [1:0] rxl1_reg, rxl2_reg;
  logic [4:0] rise;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      rxl1_reg <= 2'b11;
      rxl2_reg <= 2'b11;
    end else begin
      s1_reg <= {timer_out, ext_rx_b, ext_tx_b, input_pin_four, input_pin_three};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      rxl1_reg <= {rx_line_b, rx_line_a};
      rxl2_reg <= rxl1_reg;
    end
  end
  assign rise = s2_reg & ~s3_reg;
  // ==========
  // four independent selectors
  bit_clock_pkg::clk_en_t en_q [4];
  logic [3:0] codes [4];
  assign codes[0] = csa_reg[3:0];
  assign codes[1] = csa_reg[7:4];
  assign codes[2] = csb_reg[3:0];
  assign codes[3] = csb_reg[7:4];
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_sel
    bit_clock_pkg::clk_sel_t sel_w;
    assign sel_w.code = codes[gi];
    assign sel_w.table_sel = table_reg;
    assign sel_w.extend = ext_reg[gi];
    rate_select u_sel (
      .sys_clk(sys_clk),
      .rst(rst),
      .sel(sel_w),
      .xtal_scale(xtal_scale),
      .timer_tick(rise[4]),
      .ext_tick(rise[gi]),
      .en(en_q[gi])
    );
  end
  // ==========
  // transmitter enables and receiver sampling
  logic [1:0] tx_en_reg, tx_en_next;
  rx_state_t st_reg [2];
  rx_state_t st_next [2];
  logic [3:0] div_reg [2];
  logic [3:0] div_next [2];
  logic [3:0] nbit_reg [2];
  logic [3:0] nbit_next [2];
  logic [1:0] samp_reg, samp_next;
  always_comb begin
    tx_en_next = {en_q[2].tick, en_q[0].tick};
    for (int c = 0; c < 2; c++) begin
      st_next[c] = st_reg[c];
      div_next[c] = div_reg[c];
      nbit_next[c] = nbit_reg[c];
      samp_next[c] = 1'b0;
      if (en_q[2*c+1].tick) begin
        case (st_reg[c])
          rx_idle: begin
            div_next[c] = 4'h0;
            nbit_next[c] = 4'h0;
            if (!rxl2_reg[c]) begin
              if (en_q[2*c+1].is_1x) begin
                samp_next[c] = 1'b1;
                st_next[c] = rx_bits;
              end else begin
                st_next[c] = rx_mid;
              end
            end
          end
          rx_mid: begin
            div_next[c] = 4'(div_reg[c] + 4'h1);
            if (rxl2_reg[c]) begin
              st_next[c] = rx_idle;
            end else if (div_reg[c] == 4'(bit_clock_pkg::mid_count - 4'h1)) begin
              samp_next[c] = 1'b1;
              div_next[c] = 4'h0;
              st_next[c] = rx_bits;
            end
          end
          rx_bits: begin
            div_next[c] = 4'(div_reg[c] + 4'h1);
            if (en_q[2*c+1].is_1x || div_reg[c] == bit_clock_pkg::bit_count) begin
              samp_next[c] = 1'b1;
              div_next[c] = 4'h0;
              nbit_next[c] = 4'(nbit_reg[c] + 4'h1);
              if (nbit_reg[c] == 4'(bit_clock_pkg::frame_bits - 4'h2)) begin
                st_next[c] = rx_idle;
              end
            end
          end
          default: st_next[c] = rx_idle;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csa_reg <= 8'h00;
      csb_reg <= 8'h00;
      table_reg <= 1'b0;
      ext_reg <= 4'h0;
      rdata_reg <= 8'h00;
      tx_en_reg <= 2'b00;
      samp_reg <= 2'b00;
      rx_busy_reg <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        st_reg[c] <= rx_idle;
        div_reg[c] <= 4'h0;
        nbit_reg[c] <= 4'h0;
      end
    end else begin
      csa_reg <= csa_next;
      csb_reg <= csb_next;
      table_reg <= table_next;
      ext_reg <= ext_next;
      rdata_reg <= rdata_next;
      tx_en_reg <= tx_en_next;
      samp_reg <= samp_next;
      for (int c = 0; c < 2; c++) begin
        st_reg[c] <= st_next[c];
        div_reg[c] <= div_next[c];
        nbit_reg[c] <= nbit_next[c];
        rx_busy_reg[c] <= (st_next[c] != rx_idle);
      end
    end
  end
  assign reg_rdata = rdata_reg;
  assign tx_clk_en_a = tx_en_reg[0];
  assign tx_clk_en_b = tx_en_reg[1];
  assign rx_sample_a = samp_reg[0];
  assign rx_sample_b = samp_reg[1];
  assign rx_busy = rx_busy_reg;
  // ==========
  // checks
  a_table_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_aux |=> table_reg == $past(reg_wdata[7]))
    else $error("table bit not taken");
  a_rx_ext_set: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_cmda && reg_wdata == 8'h08 |=> ext_reg[1])
    else $error("rx extend not set");
  a_tx_ext_clr: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_cmdb && reg_wdata == 8'h0B |=> !ext_reg[2])
    else $error("tx extend not cleared");
  a_cs_nibbles: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_csa |=> codes[1] == $past(reg_wdata[7:4])
    && codes[0] == $past(reg_wdata[3:0]))
    else $error("clock select nibbles wrong");
  a_timer_route: assert property (@(posedge sys_clk) disable iff (rst)
    codes[0] == 4'hD && $stable(codes[0]) && rise[4] |=> en_q[0].tick)
    else $error("timer tick not routed");
  a_ext_route: assert property (@(posedge sys_clk) disable iff (rst)
    codes[1] == 4'hF && $stable(codes[1]) && rise[1] |=> en_q[1].tick && en_q[1].is_1x)
    else $error("pin four not routed");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (rst)
    rise[0] |-> $past(input_pin_three, 2) && !$past(input_pin_three, 3))
    else $error("external edge not synchronised");
  a_bit_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    samp_reg[0] && st_reg[0] == rx_bits && !en_q[1].is_1x |=> !samp_reg[0] [*8])
    else $error("samples too close");
  a_tx_ext_set: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_cmda && reg_wdata == 8'h0A |=> ext_reg[0])
    else $error("tx extend not set");
  a_rx_ext_clr: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_cmdb && reg_wdata == 8'h09 |=> !ext_reg[3])
    else $error("rx extend not cleared");
  a_cmd_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_cmda && reg_wdata[7:2] != 6'h02 |=> $stable(ext_reg))
    else $error("unknown command changed extend");
  a_csb_nibbles: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == bit_clock_pkg::addr_csb |=> codes[3] == $past(reg_wdata[7:4])
    && codes[2] == $past(reg_wdata[3:0]))
    else $error("channel b nibbles wrong");
  a_select_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_wr |=> $stable(csa_reg) && $stable(csb_reg))
    else $error("select changed without write");

  a_timer_route_b: assert property (@(posedge sys_clk) disable iff (rst)
    codes[2] == bit_clock_pkg::code_timer && rise[4] |=> en_q[2].tick)
    else $error("timer tick not routed to b");
  a_ext16_route: assert property (@(posedge sys_clk) disable iff (rst)
    codes[0] == bit_clock_pkg::code_ext16 && rise[0] |=> en_q[0].tick && !en_q[0].is_1x)
    else $error("pin three 16x not routed");
  a_rx_b_route: assert property (@(posedge sys_clk) disable iff (rst)
    codes[3] == bit_clock_pkg::code_ext1 && rise[3] |=> en_q[3].tick && en_q[3].is_1x)
    else $error("b receiver 1x not routed");
  a_tx_b_route: assert property (@(posedge sys_clk) disable iff (rst)
    codes[2] == bit_clock_pkg::code_ext16 && rise[2] |=> en_q[2].tick)
    else $error("b transmitter 16x not routed");
  a_gen_no_1x: assert property (@(posedge sys_clk) disable iff (rst)
    codes[0] <= bit_clock_pkg::code_last_gen |=> !en_q[0].is_1x)
    else $error("generator marked 1x");

  a_tx_follow: assert property (@(posedge sys_clk) disable iff (rst)
    en_q[0].tick |=> tx_clk_en_a)
    else $error("tx a enable missing");
  a_tx_b_follow: assert property (@(posedge sys_clk) disable iff (rst)
    en_q[2].tick |=> tx_clk_en_b)
    else $error("tx b enable missing");
  a_sample_1x: assert property (@(posedge sys_clk) disable iff (rst)
    en_q[1].tick && en_q[1].is_1x && st_reg[0] == rx_bits |=> samp_reg[0])
    else $error("1x sample missing");
  a_idle_no_sample: assert property (@(posedge sys_clk) disable iff (rst)
    st_reg[0] == rx_idle && rxl2_reg[0] |=> !samp_reg[0])
    else $error("sample while idle");
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_out_reset: assert property (@(posedge sys_clk)
    rst |=> !tx_clk_en_a && !tx_clk_en_b && !rx_sample_a && !rx_sample_b
    && rx_busy == 2'b00)
    else $error("outputs not cleared by reset");

  c_mid: cover property (@(posedge sys_clk) st_reg[0] == rx_mid ##1 st_reg[0] == rx_bits);
  c_frame: cover property (@(posedge sys_clk) st_reg[0] == rx_bits ##1 st_reg[0] == rx_idle);
  c_tx_tick: cover property (@(posedge sys_clk) tx_clk_en_b);
  c_ext_1x: cover property (@(posedge sys_clk) en_q[1].tick && en_q[1].is_1x);
  c_timer_b: cover property (@(posedge sys_clk) en_q[2].tick && codes[2] == 4'hD);
endmodule
`default_nettype wire

// File: verif/remote_serial_tx.sv
/*
  remote serial transmitter model driving one receive line.
  assumes send is a one-cycle pulse given while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_serial_tx (
  // clock
  input wire logic sys_clk,
  // request
  input wire logic send,
  input wire logic [7:0] data,
  input wire logic [15:0] bit_cyc,
  // line side
  output logic line,
  output logic busy
);
  logic [10:0] frame;
  logic [15:0] per;
  logic [15:0] cnt;
  logic [3:0] left;
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  // ==========================================
  // start, data lsb first, even parity, stop; idle high
  always @(posedge sys_clk) begin
    if (send && !busy) begin
      frame <= {1'b1, ^data, data, 1'b0};
      per <= bit_cyc;
      cnt <= 16'h0000;
      left <= 4'hB;
      busy <= 1'b1;
    end else if (busy) begin
      line <= frame[0];
      if (cnt == per - 16'h0001) begin
        cnt <= 16'h0000;
        frame <= frame >> 1;
        left <= left - 4'h1;
        if (left == 4'h1) begin
          busy <= 1'b0;
        end
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/uart_bit_clock_select_tb.sv
/*
  testbench for the bit-clock selector, with a remote transmitter on line a.
  assumes read data stand in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_bit_clock_select_tb;
  logic sys_clk, rst, reg_wr, reg_rd, send, rx_line_b, line_a, busy_a;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val, tx_data;
  logic [4:0] src;
  logic [15:0] bit_cyc;
  logic [1:0] rx_busy;
  wire logic [3:0] outs;
  int errors, n_compared;
  int cyc = 0;
  int pc [4];
  int st [$];
  logic sb [$];
  logic run16 = 1'b0;

  uart_bit_clock_select dut_u (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_out(src[0]),
    .input_pin_three(src[1]), .input_pin_four(src[2]), .ext_tx_b(src[3]),
    .ext_rx_b(src[4]), .rx_line_a(line_a), .rx_line_b(rx_line_b),
    .tx_clk_en_a(outs[0]), .tx_clk_en_b(outs[1]), .rx_sample_a(outs[2]),
    .rx_sample_b(outs[3]), .rx_busy(rx_busy));
  remote_serial_tx far_u (.sys_clk(sys_clk), .send(send), .data(tx_data),
    .bit_cyc(bit_cyc), .line(line_a), .busy(busy_a));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================
  // pulse counters, sample log, 16x source, timeout
  always @(posedge sys_clk) begin
    cyc++;
    for (int i = 0; i < 4; i++) if (outs[i] === 1'b1) pc[i]++;
    if (outs[2] === 1'b1) begin
      st.push_back(cyc);
      sb.push_back(line_a);
    end
    if (run16 && cyc % 4 == 0) src[2] <= ~src[2];
    if (cyc == 90000) begin
      errors++;
      stop_test();
    end
  end
  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic ext_cnt(input int b, input logic [15:0] e);
    #1;
    pc = '{0, 0, 0, 0};
    repeat (6) begin
      @(posedge sys_clk);
      src[b] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      src[b] <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) chk($sformatf("pulses %0d", i), e[i*4 +: 4], pc[i]);
  endtask
  task automatic rate_chk(input logic t, input logic x, input logic [3:0] c, input int r);
    int n;
    int e;
    e = $rtoi(2.0e8 / (16.0 * r));
    wr(bit_clock_pkg::addr_aux, {t, 7'h00});
    wr(bit_clock_pkg::addr_cmda, x ? bit_clock_pkg::cmd_tx_ext_set : 8'h0B);
    wr(bit_clock_pkg::addr_csa, {4'hE, c});
    repeat (6) @(posedge sys_clk);
    do begin @(posedge sys_clk); #1; end while (outs[0] !== 1'b1);
    n = cyc;
    repeat (8) do begin @(posedge sys_clk); #1; end while (outs[0] !== 1'b1);
    n = cyc - n;
    chk($sformatf("eight periods code %0h", c), e + (n > e), n);
  endtask
  task automatic send_chr(input logic [7:0] d, input logic [15:0] b, input int k);
    int t0;
    @(posedge sys_clk);
    tx_data <= d;
    bit_cyc <= b;
    send <= 1'b1;
    t0 = cyc;
    @(posedge sys_clk);
    send <= 1'b0;
    repeat (300) @(posedge sys_clk);
    #1;
    chk("rx busy a", 1'b1, rx_busy[0]);
    do begin @(posedge sys_clk); #1; end while (busy_a === 1'b1);
    repeat (200) @(posedge sys_clk);
    t0 = st[k] - t0;
    chk("start midpoint", (t0 < 56) ? 56 : ((t0 > 80) ? 80 : t0), t0);
    for (int i = 0; i < 11; i++) chk("rx bit", (i == 10) ? 1'b1 : ((i == 9) ? ^d :
      ((i == 0) ? 1'b0 : d[i - 1])), sb[k + i]);
    for (int i = 0; i < 10; i++) chk("bit spacing", 128, st[k + i + 1] - st[k + i]);
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    logic [7:0] cmd [8] = '{8'h08, 8'h0A, 8'h08, 8'h0A, 8'h09, 8'h0B, 8'h09, 8'h0B};
    logic [7:0] ex [8] = '{8'h02, 8'h03, 8'h0B, 8'h0F, 8'h0D, 8'h0C, 8'h04, 8'h00};
    rd(bit_clock_pkg::addr_stat);
    chk("status reset", 8'h00, rd_val);
    wr(bit_clock_pkg::addr_csa, 8'h5A);
    rd(bit_clock_pkg::addr_csa);
    chk("select read", 8'h00, rd_val);
    rd(3'h7);
    chk("unmapped read", 8'h00, rd_val);
    for (int i = 0; i < 8; i++) begin
      wr((i % 4 < 2) ? bit_clock_pkg::addr_cmda : bit_clock_pkg::addr_cmdb, cmd[i]);
      rd(bit_clock_pkg::addr_stat);
      chk("status extend", ex[i], rd_val);
    end
    wr(bit_clock_pkg::addr_cmda, 8'h07);
    wr(bit_clock_pkg::addr_aux, 8'h80);
    rd(bit_clock_pkg::addr_stat);
    chk("status table", 8'h80, rd_val);
    wr(bit_clock_pkg::addr_aux, 8'h7F);
    rd(bit_clock_pkg::addr_stat);
    chk("status table", 8'h00, rd_val);
  endtask
  task automatic t_src();
    wr(bit_clock_pkg::addr_csa, 8'hFE);
    wr(bit_clock_pkg::addr_csb, 8'hFE);
    ext_cnt(1, 16'h0006);
    ext_cnt(2, 16'h0000);
    ext_cnt(3, 16'h0060);
    rx_line_b <= 1'b0;
    ext_cnt(4, 16'h6000);
    rx_line_b <= 1'b1;
    wr(bit_clock_pkg::addr_csa, 8'hED);
    wr(bit_clock_pkg::addr_csb, 8'hED);
    ext_cnt(0, 16'h0066);
  endtask
  task automatic t_frame();
    wr(bit_clock_pkg::addr_csa, 8'hEE);
    run16 <= 1'b1;
    repeat (16) @(posedge sys_clk);
    st.delete();
    sb.delete();
    send_chr(8'hA5, 16'd128, 0);
    send_chr(8'h3C, 16'd132, 11);
    chk("sample count", 22, st.size());
  endtask

  initial begin
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, send, tx_data, src} = '0;
    rx_line_b = 1'b1;
    bit_cyc = 16'd128;
    errors = 0;
    n_compared = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_src();
    rate_chk(1'b0, 1'b0, 4'hC, 38400);
    rate_chk(1'b0, 1'b0, 4'hA, 7200);
    rate_chk(1'b0, 1'b1, 4'hC, 19200);
    rate_chk(1'b0, 1'b1, 4'h8, 115200);
    rate_chk(1'b0, 1'b1, 4'h4, 3600);
    rate_chk(1'b1, 1'b0, 4'hC, 19200);
    rate_chk(1'b1, 1'b0, 4'h7, 2000);
    rate_chk(1'b1, 1'b0, 4'hA, 1800);
    rate_chk(1'b1, 1'b1, 4'hC, 38400);
    t_frame();
    stop_test();
  end
endmodule
`default_nettype wire
